// [verilog/stack_sizing_map.vh]
// Constants for the stack push/pop sizing unit
// Functional notes
// R01: Selector push writes 4 bytes, upper zero
// R02: Selector pop reads 4, keeps low two
// R03: Pop beyond limit at pointer+4 faults; code faults only when pointer+3 passes the limit (pointer+1 on 16-bit)
// R04: Error code is 32 bits, upper zero
// R05: Error code push stores 4, pointer minus 4
// R06: Check far-call target before any push
// R07: Branch fault means limit or rights violation
// R08: 16-bit gate saves low 16 pointer bits
// R09: Return pops 16-bit value into full pointer
// R10: Rebuilt pointer upper half is zero
// R11: Stack size from descriptor default-size flag
// R12: Pre-decrement on push, post-increment on pop
`ifndef STACK_SIZING_MAP_VH
`define STACK_SIZING_MAP_VH
`define SLOT_BYTES      32'h0000_0004
`define HALF_BYTES      32'h0000_0002
`define OP_PUSH_SEL     3'h0
`define OP_POP_SEL      3'h1
`define OP_PUSH_ERR     3'h2
`define OP_FAR_CALL     3'h3
`define OP_GATE_SAVE    3'h4
`define OP_RET_REBUILD  3'h5
`define RST_POINTER     32'h0000_0000
`endif

// [verilog/stack_limit_check.v]
// Stack segment limit check for one access
`timescale 1ns/1ps
module stack_limit_check (
  // Access
  input  wire [31:0] addr,
  input  wire [31:0] size,
  input  wire [31:0] limit,
  // Result
  output wire        over
);
  wire [32:0] last_byte;
  assign last_byte = {1'b0, addr} + {1'b0, size} - 33'h0_0000_0001;
  // Access runs past the limit, or wraps past the top of the space
  assign over = (last_byte > {1'b0, limit});
endmodule

// [verilog/stack_sizing_unit.v]
// Stack push/pop sizing, limit check and pointer rebuild sequencer
`timescale 1ns/1ps
`include "stack_sizing_map.vh"
module stack_sizing_unit (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        nrst,
  // Operation request
  input  wire        op_valid,
  input  wire [2:0]  op_code,
  input  wire [15:0] op_selector,
  input  wire [15:0] op_error_code,
  input  wire [31:0] op_call_cs,
  input  wire [31:0] op_call_ip,
  input  wire        target_limit_viol,
  input  wire        target_rights_viol,
  // Stack segment descriptor state
  input  wire        ss_default_big,
  input  wire [31:0] ss_limit,
  input  wire        sp_load,
  input  wire [31:0] sp_load_value,
  // Stack memory
  output reg         mem_req,
  output reg         mem_we,
  output reg  [31:0] mem_addr,
  output reg  [31:0] mem_wdata,
  output reg  [3:0]  mem_be,
  input  wire        mem_ack,
  input  wire [31:0] mem_rdata,
  // Results
  output reg         op_busy,
  output reg         op_done,
  output reg  [15:0] popped_selector,
  output reg         stack_fault,
  output reg         branch_fault,
  output reg  [31:0] stack_pointer_reg,
  output reg  [31:0] instruction_pointer_reg
);

  ////////////////////////////////////////////////////////////////
  localparam ST_IDLE  = 3'h0;
  localparam ST_WRITE = 3'h1;
  localparam ST_READ  = 3'h2;
  localparam ST_WAIT  = 3'h3;
  localparam ST_DONE  = 3'h4;

  reg [2:0]  state_reg;
  reg [2:0]  state_next;
  reg [2:0]  op_reg;
  reg        second_reg;
  reg [31:0] hold_reg;
  reg [31:0] ip_hold_reg;
  reg [31:0] stack_pointer_next;

  // Width of a pointer step depends on the stack segment size flag
  function [31:0] step_size;
    input big;
    begin
      step_size = big ? `SLOT_BYTES : `HALF_BYTES; // R11
    end
  endfunction

  function [31:0] zero_ext16;
    input [15:0] v;
    begin
      zero_ext16 = {16'h0000, v};
    end
  endfunction

  // Byte lanes of one slot: all four on a 32-bit stack, two on a 16-bit one
  function [3:0] slot_be;
    input big;
    begin
      slot_be = big ? 4'hf : 4'h3; // R11
    end
  endfunction

  // A branch fault is a limit or a rights violation on the target
  function target_fault;
    input lim_viol;
    input rights_viol;
    begin
      target_fault = lim_viol | rights_viol; // R07
    end
  endfunction

  // Pops read a slot first; a selector pop then raises the pointer, a return rebuild loads it from the slot
  function is_pop;
    input [2:0] code;
    begin
      is_pop = (code == `OP_POP_SEL) || (code == `OP_RET_REBUILD);
    end
  endfunction

  // Pushes lower the pointer first and then write a slot
  function is_push;
    input [2:0] code;
    begin
      is_push = (code == `OP_PUSH_SEL) || (code == `OP_PUSH_ERR) || (code == `OP_GATE_SAVE);
    end
  endfunction

  wire [31:0] step;
  wire [31:0] sp_dec;
  wire [31:0] sp_inc;
  wire        pop_over;
  wire        push_over;
  wire        branch_hit;
  assign step       = step_size(ss_default_big);
  assign sp_dec     = stack_pointer_reg - step;
  assign sp_inc     = stack_pointer_reg + step;
  assign branch_hit = target_fault(target_limit_viol, target_rights_viol);

  stack_limit_check u_pop_check (
    .addr  (stack_pointer_reg),
    .size  (step),
    .limit (ss_limit),
    .over  (pop_over)
  );

  stack_limit_check u_push_check (
    .addr  (sp_dec),
    .size  (step),
    .limit (ss_limit),
    .over  (push_over)
  );

  ////////////////////////////////////////////////////////////////
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (op_valid) begin
          state_next = ST_DONE;
          if (is_pop(op_code)) begin
            if (!pop_over) begin
              state_next = ST_READ;
            end
          end else if (op_code == `OP_FAR_CALL) begin
            // Target checked first so a fault leaves memory untouched
            if (!branch_hit && !push_over) begin // R06 R07
              state_next = ST_WRITE;
            end
          end else if (is_push(op_code)) begin
            if (!push_over) begin
              state_next = ST_WRITE;
            end
          end
        end
      end
      ST_WRITE: state_next = ST_WAIT;
      ST_READ:  state_next = ST_WAIT;
      ST_WAIT: begin
        if (mem_ack) begin
          if (op_reg == `OP_FAR_CALL && !second_reg) begin
            state_next = ST_WRITE;
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_DONE:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Sequencer and operand capture; operands are taken with the request
  always @(posedge ref_clk) begin
    if (!nrst) begin
      state_reg   <= ST_IDLE;
      op_reg      <= 3'h0;
      second_reg  <= 1'b0;
      hold_reg    <= 32'h0000_0000;
      ip_hold_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE && op_valid) begin
        op_reg      <= op_code;
        second_reg  <= 1'b0;
        ip_hold_reg <= op_call_ip;
        case (op_code)
          `OP_PUSH_SEL:  hold_reg <= zero_ext16(op_selector);             // R01
          `OP_PUSH_ERR:  hold_reg <= zero_ext16(op_error_code);           // R04
          `OP_GATE_SAVE: hold_reg <= zero_ext16(stack_pointer_reg[15:0]); // R08
          `OP_FAR_CALL:  hold_reg <= op_call_cs;
          default:       hold_reg <= 32'h0000_0000;
        endcase
      end else if (state_reg == ST_WAIT && mem_ack && op_reg == `OP_FAR_CALL && !second_reg) begin
        // Second slot of a far call carries the saved instruction pointer
        second_reg <= 1'b1;
        hold_reg   <= ip_hold_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Stack pointer, one next-value path for loads, pushes and pops
  always @* begin
    stack_pointer_next = stack_pointer_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sp_load) begin
          stack_pointer_next = sp_load_value;
        end
      end
      ST_WRITE: begin
        // Pointer drops before the slot is written
        stack_pointer_next = sp_dec; // R12 R05
      end
      ST_WAIT: begin
        if (mem_ack && op_reg == `OP_POP_SEL) begin
          stack_pointer_next = sp_inc; // R12
        end else if (mem_ack && op_reg == `OP_RET_REBUILD) begin
          // Upper half cleared, never the stack selector
          stack_pointer_next = zero_ext16(mem_rdata[15:0]); // R09 R10
        end
      end
      default: stack_pointer_next = stack_pointer_reg;
    endcase
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      stack_pointer_reg <= `RST_POINTER;
    end else begin
      stack_pointer_reg <= stack_pointer_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Memory port: a request stands from its issue until acknowledged
  always @(posedge ref_clk) begin
    if (!nrst) begin
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_addr  <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      mem_be    <= 4'h0;
    end else begin
      case (state_reg)
        ST_WRITE: begin
          mem_req   <= 1'b1;
          mem_we    <= 1'b1;
          mem_addr  <= sp_dec;
          mem_wdata <= hold_reg; // R01 R05
          mem_be    <= slot_be(ss_default_big);
        end
        ST_READ: begin
          mem_req  <= 1'b1;
          mem_we   <= 1'b0;
          mem_addr <= stack_pointer_reg;
          mem_be   <= slot_be(ss_default_big); // R02
        end
        ST_WAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we  <= 1'b0;
          end
        end
        default: mem_req <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Status and results; fault flags stand until the next request
  always @(posedge ref_clk) begin
    if (!nrst) begin
      op_busy                 <= 1'b0;
      op_done                 <= 1'b0;
      popped_selector         <= 16'h0000;
      stack_fault             <= 1'b0;
      branch_fault            <= 1'b0;
      instruction_pointer_reg <= 32'h0000_0000;
    end else begin
      op_done <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (op_valid) begin
            op_busy      <= 1'b1;
            branch_fault <= 1'b0;
            if (is_pop(op_code)) begin
              stack_fault <= pop_over; // R03
            end else if (op_code == `OP_FAR_CALL) begin
              branch_fault <= branch_hit; // R07
              stack_fault  <= !branch_hit && push_over;
            end else if (is_push(op_code)) begin
              stack_fault <= push_over;
            end else begin
              stack_fault <= 1'b0;
            end
          end
        end
        ST_WRITE, ST_READ: op_busy <= 1'b1;
        ST_WAIT: begin
          if (mem_ack && op_reg == `OP_POP_SEL) begin
            popped_selector <= mem_rdata[15:0]; // R02
          end else if (mem_ack && op_reg == `OP_FAR_CALL && second_reg) begin
            instruction_pointer_reg <= ip_hold_reg;
          end
        end
        ST_DONE: begin
          op_busy <= 1'b0;
          op_done <= 1'b1;
        end
        default: op_busy <= 1'b0;
      endcase
    end
  end

endmodule

// [verif/stack_sizing_unit_props.sv]
// Checker for the stack sizing unit
`timescale 1ns/1ps
module stack_sizing_unit_props (
  // Watched ports
  input logic ref_clk, nrst, op_valid, op_busy, op_done, target_limit_viol, target_rights_viol,
  input logic ss_default_big, mem_req, mem_we, mem_ack, stack_fault, branch_fault,
  input logic [2:0] op_code,
  input logic [3:0] mem_be,
  input logic [31:0] ss_limit, mem_addr, mem_wdata, stack_pointer_reg
);
  logic [2:0] cur;
  // Op kind shows only on the request edge, so keep it
  always_ff @(posedge ref_clk) begin
    if (op_valid && !op_busy) cur <= op_code;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_UPPER_ZERO: assert property ((cur == 0 || cur == 2) && ss_default_big && mem_req
    |-> mem_we && mem_be == 4'hf && mem_wdata[31:16] == 0) else $error("slot upper half");
  AST_AT_POINTER: assert property (mem_req |-> mem_addr == stack_pointer_reg)
    else $error("slot address");
  AST_POP_STEP: assert property (cur == 1 && mem_req && mem_ack && !mem_we
    |=> stack_pointer_reg == $past(stack_pointer_reg) + (ss_default_big ? 4 : 2)) else $error("pop step");
  AST_POP_FAULT: assert property (op_valid && !op_busy && op_code == 1 && ss_default_big
    && stack_pointer_reg + 33'h3 > ss_limit |-> ##2 op_done && stack_fault) else $error("pop fault");
  AST_BRANCH: assert property (op_valid && !op_busy && op_code == 3
    && (target_limit_viol || target_rights_viol) |=> !mem_req ##1 op_done && branch_fault) else $error("branch");
  AST_REBUILD: assert property (cur == 5 && mem_req && mem_ack |=> stack_pointer_reg[31:16] == 0)
    else $error("rebuild");
  AST_GATE_SAVE: assert property (cur == 4 && ss_default_big && mem_req
    |-> mem_wdata[15:0] == stack_pointer_reg[15:0] + 16'h4) else $error("gate save");
  AST_DONE_PULSE: assert property (op_done |=> !op_done) else $error("done pulse");
  cover property (op_done && stack_fault);
  cover property (op_done && branch_fault);
  cover property (mem_req && mem_be == 4'h3);
endmodule
bind stack_sizing_unit stack_sizing_unit_props props_i (.*);

// [verif/stack_mem_model.sv]
// Stack memory partner answering after 0 to 3 idle cycles
`timescale 1ns/1ps
module stack_mem_model (
  // Memory side
  input wire ref_clk, mem_req, mem_we,
  input wire [31:0] mem_addr, mem_wdata,
  output reg mem_ack,
  output reg [31:0] mem_rdata
);
  // Word store for the stack windows the bench uses, one entry per half-word address
  reg [31:0] mem [0:65535];
  integer seed = 33, dly = 0;
  initial {mem_ack, mem_rdata} = 0;
  always @(posedge ref_clk) begin
    mem_ack <= 0;
    // Data flips outside an answer so a sample one cycle late never looks right
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && dly > 0) dly = dly - 1;
    else if (mem_req && !mem_ack) begin
      mem_ack <= 1;
      dly = $random(seed) & 3;
      if (mem_we) mem[mem_addr[16:1]] = mem_wdata;
      else mem_rdata <= mem[mem_addr[16:1]];
    end
  end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the stack sizing unit
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, nrst, op_valid, target_limit_viol, target_rights_viol, sp_load, mem_req, mem_we;
  logic ss_default_big, mem_ack, op_busy, op_done, stack_fault, branch_fault;
  logic [2:0] op_code, seq [8] = '{0, 3, 4, 1, 1, 5, 2, 1}, pp [2] = '{0, 1};
  logic [3:0] mem_be;
  logic [15:0] op_selector, op_error_code, popped_selector;
  logic [31:0] op_call_cs, op_call_ip, ss_limit, sp_load_value, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] stack_pointer_reg, instruction_pointer_reg, ipm, stk [$];
  logic [68:0] seen [$], want [$];
  integer seed = 33, n_mismatch = 0, total_checks = 0, sp, i, k;
  stack_sizing_unit uut (.*);
  stack_mem_model mem_i (.*);
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (mem_req && mem_ack) seen.push_back({mem_we, mem_addr, mem_we ? {mem_be, mem_wdata} : 36'h0});
  task chk(input string s, input logic [68:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task conclude;
    if (n_mismatch == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [31:0] d);
    sp -= ss_default_big ? 4 : 2;
    stk.push_front(d);
    want.push_back({1'b1, 32'(sp), ss_default_big ? 4'hf : 4'h3, d});
  endtask
  task rd(output logic [31:0] d);
    d = stk.pop_front();
    want.push_back({1'b0, 32'(sp), 36'h0});
    sp += ss_default_big ? 4 : 2;
  endtask
  task ld(input logic [31:0] v);
    @(negedge ref_clk);
    sp_load = 1;
    sp_load_value = v;
    sp = v;
    @(negedge ref_clk);
    sp_load = 0;
  endtask
  task run(input logic [2:0] c);
    logic [31:0] d;
    logic [1:0] f;
    f = 0;
    @(negedge ref_clk);
    op_code = c;
    op_valid = 1;
    @(negedge ref_clk);
    op_valid = 0;
    case (c)
      0: wr({16'h0, op_selector});
      1: if (sp + (ss_default_big ? 3 : 1) > ss_limit) f = 2;
         else rd(d);
      2: wr({16'h0, op_error_code});
      3: if (target_limit_viol | target_rights_viol) f = 1;
         else begin
           wr(op_call_cs);
           wr(op_call_ip);
           ipm = op_call_ip;
         end
      4: wr({16'h0, 16'(sp)});
      5: begin
        rd(d);
        sp = d[15:0];
      end
    endcase
    for (k = 0; k < 40 && op_done !== 1'b1; k++) @(negedge ref_clk);
    // A timeout counts once; the run still ends at the closing verdict
    if (k == 40) n_mismatch++;
    chk("flags and pointer", {f, 1'b0, 32'(sp)}, {stack_fault, branch_fault, op_busy, stack_pointer_reg});
    chk("instruction_pointer_reg", ipm, instruction_pointer_reg);
    if (c == 1 && !f) chk("popped_selector", d[15:0], popped_selector);
    while (want.size() || seen.size()) chk("access", want.size() ? want.pop_front() : 0,
      seen.size() ? seen.pop_front() : 0);
  endtask
  initial begin
    {nrst, op_valid, target_limit_viol, target_rights_viol, sp_load, op_code, sp_load_value, sp} = 0;
    {op_selector, op_error_code, op_call_cs, op_call_ip, ipm} = 0;
    ss_default_big = 1;
    ss_limit = 32'hffff_ffff;
    repeat (20) @(negedge ref_clk);
    nrst = 1;
    for (i = 0; i < 9; i++) begin
      {op_selector, op_error_code, op_call_ip} = {$random(seed), $random(seed)};
      op_call_cs = $random(seed) | 32'h8000;
      ld(32'h1000);
      foreach (seq[j]) run(seq[j]);
      {target_limit_viol, target_rights_viol} = i % 3 + 1;
      run(3);
      {target_limit_viol, target_rights_viol} = 0;
    end
    // Last legal slot pops, the next one is past the limit
    ss_limit = 32'h2003;
    ld(32'h2004);
    foreach (pp[j]) run(pp[j]);
    run(1);
    ss_limit = 32'hffff_ffff;
    ss_default_big = 0;
    ld(32'h3000);
    foreach (pp[j]) run(pp[j]);
    conclude;
  end
endmodule
